/* include/gpk_consts.vh */
// Purpose: shared constants of the gpk parallel port controller
// Assumes: apb byte addresses are four times the register index
// Notes  : definitions only, no logic
`ifndef GPK_CONSTS_VH
`define GPK_CONSTS_VH

// register indices (byte address = index * 4)
`define GPK_IDX_A_VAL      6'h00
`define GPK_IDX_A_DIR      6'h01
`define GPK_IDX_B_VAL      6'h02
`define GPK_IDX_B_DIR      6'h03
`define GPK_IDX_C_VAL      6'h04
`define GPK_IDX_C_DIR      6'h05
`define GPK_IDX_A_IRQ_EN   6'h06
`define GPK_IDX_A_POL      6'h07
`define GPK_IDX_C_PULL_EN  6'h08
`define GPK_IDX_C_SLEW_EN  6'h09
`define GPK_IDX_A_PULL_EN  6'h0a
`define GPK_IDX_IRQ_STAT   6'h0b
`define GPK_IDX_IRQ_MASK   6'h0c
`define GPK_IDX_IRQ_CTRL   6'h0d

// address split
`define GPK_ADDR_W         8
`define GPK_IDX_LSB        2
`define GPK_BYTE_LANE_W    2
`define GPK_LANE_ZERO      2'h0

// reset values
`define GPK_RST_BYTE       8'h00
`define GPK_RST_BIT        1'b0
`define GPK_RST_WORD       32'h0000_0000

// irq control field: bit 0 selects level detection
`define GPK_CTRL_LEVEL_BIT 0

// data bus width
`define GPK_DATA_W         32

`endif

/* hdl/gpk_pin_irq.v */
// Purpose: per-pin interrupt condition detectors for port a
// Assumes: pin levels are synchronous to pclk
// Notes  : one cycle event pulse per detected edge, held every cycle while active in level mode
`timescale 1ns/100ps
`default_nettype none
`include "gpk_consts.vh"

module gpk_pin_irq #(
  parameter NPIN = 4
) (
  input  wire            pclk,
  input  wire            presetn,
  input  wire            ce,
  input  wire [NPIN-1:0] pin_lvl,
  input  wire [NPIN-1:0] src_en,
  input  wire [NPIN-1:0] pol_hi,
  input  wire            level_mode,
  output wire [NPIN-1:0] event_p
);

  ////////////////////////////////////////////////////////////////////
  // one detector per pin
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : det
      wire act;     // pin sits at its active level
      reg  act_q;   // active level one cycle ago

      // polarity flips the active level: 0 low/falling, 1 high/rising
      assign act = pol_hi[g] ? pin_lvl[g] : ~pin_lvl[g]; // [RULE_02] [RULE_03] [RULE_04]

      // history flop, frozen while ce is low
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          act_q <= `GPK_RST_BIT;
        end else if (ce) begin
          act_q <= act;
        end
      end

      // excluded pins never raise an event; level mode repeats while held
      assign event_p[g] = src_en[g] &
                          (level_mode ? act : (act & ~act_q)); // [RULE_01]
    end
  endgenerate

endmodule
`default_nettype wire

/* hdl/gpk_port_ctrl.v */
// Purpose: three-port gpio controller with port a interrupts and pulls
// Assumes: apb3 slave, pclk 10 MHz, pin inputs synchronous to pclk
// Notes  : two-cycle access phase, all outputs registered
//
// Overview of operation
// [RULE_01] port a pin irq only when enabled
// [RULE_02] polarity 0: pull-up, falling/low detected
// [RULE_03] polarity 1: pull-down, rising/high detected
// [RULE_04] one polarity bit sets condition and pull
// [RULE_05] port c per-pin pull-up enable bits
// [RULE_06] port c output pins: pull forced off
// [RULE_07] port c slew enable, inert on inputs
// [RULE_08] direction 1 drives data, 0 reads pin
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "gpk_consts.vh"

module gpk_port_ctrl #(
  parameter PW   = 8,   // pins per port
  parameter NIRQ = 4    // port a pins able to interrupt
) (
  input  wire                    pclk,
  input  wire                    presetn,
  input  wire                    ce,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`GPK_ADDR_W-1:0]  paddr,
  input  wire [`GPK_DATA_W-1:0]  pwdata,
  output reg  [`GPK_DATA_W-1:0]  prdata,
  output reg                     pready,
  output reg                     pslverr,
  output reg                     irq,
  input  wire [PW-1:0]           pa_in,
  output reg  [PW-1:0]           pa_out,
  output reg  [PW-1:0]           pa_oe,
  output reg  [PW-1:0]           pa_pull_en,
  output reg  [PW-1:0]           pa_pull_up,
  input  wire [PW-1:0]           pb_in,
  output reg  [PW-1:0]           pb_out,
  output reg  [PW-1:0]           pb_oe,
  input  wire [PW-1:0]           pc_in,
  output reg  [PW-1:0]           pc_out,
  output reg  [PW-1:0]           pc_oe,
  output reg  [PW-1:0]           pc_pull_en,
  output reg  [PW-1:0]           pc_slew_en
);

  ////////////////////////////////////////////////////////////////////
  // software visible registers
  reg  [PW-1:0]   a_val_q;      // port a output data
  reg  [PW-1:0]   a_dir_q;      // port a direction, 1 = output
  reg  [PW-1:0]   b_val_q;      // port b output data
  reg  [PW-1:0]   b_dir_q;      // port b direction
  reg  [PW-1:0]   c_val_q;      // port c output data
  reg  [PW-1:0]   c_dir_q;      // port c direction
  reg  [NIRQ-1:0] a_irq_en_q;   // interrupt source enables
  reg  [NIRQ-1:0] a_pol_q;      // polarity / pull direction
  reg  [PW-1:0]   c_pull_en_q;  // port c pull-up enables
  reg  [PW-1:0]   c_slew_en_q;  // port c slew limit enables
  reg  [PW-1:0]   a_pull_en_q;  // port a pull enables
  reg  [NIRQ-1:0] stat_q;       // sticky interrupt status
  reg  [NIRQ-1:0] mask_q;       // interrupt mask, 1 = pass
  reg             level_q;      // 1 = level, 0 = edge detection

  ////////////////////////////////////////////////////////////////////
  // apb decode
  wire [`GPK_ADDR_W-`GPK_IDX_LSB-1:0] idx;   // register index
  wire            lane_ok;   // word aligned access
  reg             hit;       // index names a register
  reg  [PW-1:0]   rd_byte;   // read value of addressed register
  wire            acc;       // first access cycle, answer pending
  wire            done;      // completing edge of a transfer
  wire            wr_ok;     // mapped write takes effect now
  wire            rd_stat;   // status read completes now
  wire [PW-1:0]   wb;        // write data byte

  assign idx     = paddr[`GPK_ADDR_W-1:`GPK_IDX_LSB];
  assign lane_ok = (paddr[`GPK_BYTE_LANE_W-1:0] == `GPK_LANE_ZERO);
  assign acc     = psel & penable & ~pready;
  assign done    = psel & penable & pready;
  assign wr_ok   = done & pwrite & ~pslverr;
  assign rd_stat = done & ~pwrite & ~pslverr & (idx == `GPK_IDX_IRQ_STAT);
  assign wb      = pwdata[PW-1:0];

  // port value reads: output pins give data, input pins give the pin
  wire [PW-1:0] a_rd = (a_dir_q & a_val_q) | (~a_dir_q & pa_in); // [RULE_08]
  wire [PW-1:0] b_rd = (b_dir_q & b_val_q) | (~b_dir_q & pb_in); // [RULE_08]
  wire [PW-1:0] c_rd = (c_dir_q & c_val_q) | (~c_dir_q & pc_in); // [RULE_08]

  // read mux; narrow registers read zero above their width
  always @* begin
    hit     = lane_ok;
    rd_byte = `GPK_RST_BYTE;
    case (idx)
      `GPK_IDX_A_VAL:     rd_byte = a_rd;
      `GPK_IDX_A_DIR:     rd_byte = a_dir_q;
      `GPK_IDX_B_VAL:     rd_byte = b_rd;
      `GPK_IDX_B_DIR:     rd_byte = b_dir_q;
      `GPK_IDX_C_VAL:     rd_byte = c_rd;
      `GPK_IDX_C_DIR:     rd_byte = c_dir_q;
      `GPK_IDX_A_IRQ_EN:  rd_byte[NIRQ-1:0] = a_irq_en_q;
      `GPK_IDX_A_POL:     rd_byte[NIRQ-1:0] = a_pol_q;
      `GPK_IDX_C_PULL_EN: rd_byte = c_pull_en_q;
      `GPK_IDX_C_SLEW_EN: rd_byte = c_slew_en_q;
      `GPK_IDX_A_PULL_EN: rd_byte = a_pull_en_q;
      `GPK_IDX_IRQ_STAT:  rd_byte[NIRQ-1:0] = stat_q;
      `GPK_IDX_IRQ_MASK:  rd_byte[NIRQ-1:0] = mask_q;
      `GPK_IDX_IRQ_CTRL:  rd_byte[`GPK_CTRL_LEVEL_BIT] = level_q;
      default:            hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // apb answer: pready rises in the second access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= `GPK_RST_BIT;
      pslverr <= `GPK_RST_BIT;
      prdata  <= `GPK_RST_WORD;
    end else if (ce) begin
      pready <= acc;
      if (acc) begin
        // unmapped or misaligned: error answer, no side effect
        pslverr <= ~hit;
        prdata  <= (hit & ~pwrite) ?
                   {{(`GPK_DATA_W-PW){1'b0}}, rd_byte} : `GPK_RST_WORD;
      end else if (done) begin
        pslverr <= `GPK_RST_BIT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control register writes, effective at the completing edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_val_q     <= `GPK_RST_BYTE;
      a_dir_q     <= `GPK_RST_BYTE;
      b_val_q     <= `GPK_RST_BYTE;
      b_dir_q     <= `GPK_RST_BYTE;
      c_val_q     <= `GPK_RST_BYTE;
      c_dir_q     <= `GPK_RST_BYTE;
      a_irq_en_q  <= {NIRQ{1'b0}};
      a_pol_q     <= {NIRQ{1'b0}};
      c_pull_en_q <= `GPK_RST_BYTE;
      c_slew_en_q <= `GPK_RST_BYTE;
      a_pull_en_q <= `GPK_RST_BYTE;
      mask_q      <= {NIRQ{1'b0}};
      level_q     <= `GPK_RST_BIT;
    end else if (ce && wr_ok) begin
      case (idx)
        `GPK_IDX_A_VAL:     a_val_q     <= wb;
        `GPK_IDX_A_DIR:     a_dir_q     <= wb;
        `GPK_IDX_B_VAL:     b_val_q     <= wb;
        `GPK_IDX_B_DIR:     b_dir_q     <= wb;
        `GPK_IDX_C_VAL:     c_val_q     <= wb;
        `GPK_IDX_C_DIR:     c_dir_q     <= wb;
        `GPK_IDX_A_IRQ_EN:  a_irq_en_q  <= wb[NIRQ-1:0];  // [RULE_01]
        `GPK_IDX_A_POL:     a_pol_q     <= wb[NIRQ-1:0];  // [RULE_04]
        `GPK_IDX_C_PULL_EN: c_pull_en_q <= wb;            // [RULE_05]
        `GPK_IDX_C_SLEW_EN: c_slew_en_q <= wb;            // [RULE_07]
        `GPK_IDX_A_PULL_EN: a_pull_en_q <= wb;
        `GPK_IDX_IRQ_MASK:  mask_q      <= wb[NIRQ-1:0];
        `GPK_IDX_IRQ_CTRL:  level_q     <= wb[`GPK_CTRL_LEVEL_BIT];
        default:            level_q     <= level_q;   // status is read-only
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt detection on the low port a pins
  wire [NIRQ-1:0] ev;   // detected conditions, one cycle per edge, held while active in level mode

  gpk_pin_irq #(
    .NPIN       (NIRQ)
  ) u_det (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .pin_lvl    (pa_in[NIRQ-1:0]),
    .src_en     (a_irq_en_q),   // [RULE_01]
    .pol_hi     (a_pol_q),      // [RULE_04]
    .level_mode (level_q),
    .event_p    (ev)
  );

  // read clears only bits that were actually returned, so an event
  // landing between capture and completion survives; set wins over clear
  wire [NIRQ-1:0] clr    = rd_stat ? prdata[NIRQ-1:0] : {NIRQ{1'b0}};
  wire [NIRQ-1:0] stat_d = (stat_q & ~clr) | ev;

  // sticky status and level interrupt output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= {NIRQ{1'b0}};
      irq    <= `GPK_RST_BIT;
    end else if (ce) begin
      stat_q <= stat_d;
      irq    <= |(stat_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pad controls, registered so every output comes from a flop
  wire [PW-1:0] a_pull_up_d;   // pull direction per port a pin
  wire [PW-1:0] c_pull_d;      // effective port c pull enables

  // polarity 0 selects pull-up, 1 pull-down; upper pins default to up
  assign a_pull_up_d = {{(PW-NIRQ){1'b1}}, ~a_pol_q}; // [RULE_02] [RULE_03] [RULE_04]
  // an output pin never keeps its pull device on
  assign c_pull_d    = c_pull_en_q & ~c_dir_q;       // [RULE_05] [RULE_06]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_out     <= `GPK_RST_BYTE;
      pa_oe      <= `GPK_RST_BYTE;
      pa_pull_en <= `GPK_RST_BYTE;
      pa_pull_up <= `GPK_RST_BYTE;
      pb_out     <= `GPK_RST_BYTE;
      pb_oe      <= `GPK_RST_BYTE;
      pc_out     <= `GPK_RST_BYTE;
      pc_oe      <= `GPK_RST_BYTE;
      pc_pull_en <= `GPK_RST_BYTE;
      pc_slew_en <= `GPK_RST_BYTE;
    end else if (ce) begin
      pa_out     <= a_val_q;                  // [RULE_08]
      pa_oe      <= a_dir_q;                  // [RULE_08]
      pa_pull_en <= a_pull_en_q & ~a_dir_q;   // pulls only on inputs
      pa_pull_up <= a_pull_up_d;              // [RULE_02] [RULE_03]
      pb_out     <= b_val_q;                  // [RULE_08]
      pb_oe      <= b_dir_q;                  // [RULE_08]
      pc_out     <= c_val_q;                  // [RULE_08]
      pc_oe      <= c_dir_q;                  // [RULE_08]
      pc_pull_en <= c_pull_d;                 // [RULE_06]
      // slew limiting only matters on driven pins
      pc_slew_en <= c_slew_en_q & c_dir_q;    // [RULE_07]
    end
  end

endmodule
`default_nettype wire

/* bench/gpk_port_chk.sv */
// Purpose: port level assertions for gpk_port_ctrl
// Assumes: ce held high by the bench
// Notes  : attached by bind at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module gpk_port_chk #(
  parameter PW = 8
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          ce,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          irq,
  input wire logic [PW-1:0] pa_out,
  input wire logic [PW-1:0] pa_pull_up,
  input wire logic [PW-1:0] pc_oe,
  input wire logic [PW-1:0] pc_pull_en,
  input wire logic [PW-1:0] pc_slew_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write completion, the edge where registers take new data
  wire logic wr_done = pready & pwrite;
  ////////////////////////////////////////////////////////////////
  property p_answer;
    (psel && penable && !pready && ce) ##1 ce |-> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer in second access cycle");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error flag without ready");
  property p_c_pull;
    (pc_pull_en & pc_oe) == '0;
  endproperty
  a_c_pull: assert property (p_c_pull) else $error("pull on output pin");
  property p_slew;
    (pc_slew_en & ~pc_oe) == '0;
  endproperty
  a_slew: assert property (p_slew) else $error("slew on input pin");
  // port a data outputs move only after a write, one cycle of lag allowed
  property p_out;
    $changed(pa_out) |-> $past(wr_done) || $past(wr_done, 2);
  endproperty
  a_out: assert property (p_out) else $error("port a output moved without write");
  // the reset value of polarity turns pull-ups on right after release
  property p_pol;
    $changed(pa_pull_up[3:0]) |-> $past(wr_done) || $past(wr_done, 2)
      || $past(!presetn) || $past(!presetn, 2);
  endproperty
  a_pol: assert property (p_pol) else $error("pull direction moved without write");
  property p_c_en;
    $changed(pc_pull_en) |-> $past(wr_done) || $past(wr_done, 2);
  endproperty
  a_c_en: assert property (p_c_en) else $error("port c pull moved without write");
  property p_irq_fall;
    $fell(irq) |-> $past(pready) || $past(pready, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_clr: cover property ($fell(irq));
endmodule
bind gpk_port_ctrl gpk_port_chk #(.PW(PW)) u_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .irq(irq), .pa_out(pa_out),
  .pa_pull_up(pa_pull_up), .pc_oe(pc_oe), .pc_pull_en(pc_pull_en),
  .pc_slew_en(pc_slew_en));
`default_nettype wire

/* bench/gpk_pad_model.sv */
// Purpose: board side of one port, resolves pad level
// Assumes: board always drives undriven pins
// Notes  : pulls are not modelled, the board overrides them
`timescale 1ns/100ps
`default_nettype none
module gpk_pad_model #(
  parameter W = 8
) (
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] ext,
  output wire logic [W-1:0] pin
);
  // driven pins echo the pad output, others follow the board
  assign pin = (oe & out) | (~oe & ext);
endmodule
`default_nettype wire

/* bench/tb.sv */
// Purpose: self-checking bench for gpk_port_ctrl
// Assumes: ce held high, apb answer awaited without a count, the watchdog ends a hang
// Notes  : expected values come from the register map
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        pclk, presetn, ce, psel, penable, pwrite, err;
  logic [7:0]  paddr, ext_a, ext_b, ext_c;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq;
  wire  [7:0]  pa_in, pa_out, pa_oe, pa_pull_en, pa_pull_up, pb_in, pb_out, pb_oe;
  wire  [7:0]  pc_in, pc_out, pc_oe, pc_pull_en, pc_slew_en;
  int          n_mismatch, n_checks;
  gpk_port_ctrl dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .pa_in, .pa_out, .pa_oe, .pa_pull_en, .pa_pull_up,
    .pb_in, .pb_out, .pb_oe, .pc_in, .pc_out, .pc_oe, .pc_pull_en, .pc_slew_en);
  gpk_pad_model ua (.oe(pa_oe), .out(pa_out), .ext(ext_a), .pin(pa_in));
  gpk_pad_model ub (.oe(pb_oe), .out(pb_out), .ext(ext_b), .pin(pb_in));
  gpk_pad_model uc (.oe(pc_oe), .out(pc_out), .ext(ext_c), .pin(pc_in));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // no count here: a slave that never answers is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk("read data", rd, {24'h0, exp});
    chk("read error", {31'h0, err}, 32'h0);
  endtask
  // board changes port a, then the detector gets time to react
  task automatic pin(input logic [7:0] v);
    @(posedge pclk);
    ext_a <= v;
    repeat (3) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    for (int i = 0; i <= 13; i++)
      rdc(i[5:0], i == 0 ? ext_a : i == 2 ? ext_b : i == 4 ? ext_c : 8'h00);
    apb(1'b0, 6'h0e, 8'h00);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    wr(6'h03, 8'hf0);
    wr(6'h02, 8'ha5);
    rdc(6'h02, 8'hac);
    rdc(6'h03, 8'hf0);
    chk("port b out", {24'h0, pb_out}, 32'ha5);
    chk("port b oe", {24'h0, pb_oe}, 32'hf0);
    $display("t_regs done");
  endtask
  task automatic t_portc;
    wr(6'h08, 8'hff);
    wr(6'h09, 8'hff);
    wr(6'h05, 8'h0f);
    wr(6'h04, 8'h5a);
    rdc(6'h04, 8'h0a);
    chk("c pull", {24'h0, pc_pull_en}, 32'hf0);
    chk("c slew", {24'h0, pc_slew_en}, 32'h0f);
    chk("c out", {24'h0, pc_out}, 32'h5a);
    chk("c oe", {24'h0, pc_oe}, 32'h0f);
    wr(6'h08, 8'h30);
    repeat (2) @(posedge pclk);
    chk("c pull off", {24'h0, pc_pull_en}, 32'h30);
    $display("t_portc done");
  endtask
  task automatic t_irq;
    wr(6'h0c, 8'h0f);
    wr(6'h07, 8'h02);
    wr(6'h06, 8'h03);
    wr(6'h0a, 8'hff);
    apb(1'b0, 6'h0b, 8'h00);
    chk("a pull dir", {24'h0, pa_pull_up}, 32'hfd);
    chk("a pull en", {24'h0, pa_pull_en}, 32'hff);
    pin(8'hfe);
    chk("irq fall", {31'h0, irq}, 32'h1);
    rdc(6'h0b, 8'h01);
    @(posedge pclk);
    chk("irq clear", {31'h0, irq}, 32'h0);
    pin(8'hfc);
    chk("irq wrong edge", {31'h0, irq}, 32'h0);
    pin(8'hfe);
    rdc(6'h0b, 8'h02);
    pin(8'hfa);
    rdc(6'h0b, 8'h00);
    wr(6'h0c, 8'h00);
    pin(8'hfb);
    pin(8'hfa);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdc(6'h0b, 8'h01);
    wr(6'h06, 8'h01);
    wr(6'h0d, 8'h01);
    wr(6'h0c, 8'h0f);
    // mask lands at the completing edge, irq follows one edge later
    repeat (2) @(posedge pclk);
    chk("irq level", {31'h0, irq}, 32'h1);
    rdc(6'h0b, 8'h01);
    rdc(6'h0b, 8'h01);
    pin(8'hfb);
    rdc(6'h0b, 8'h01);
    rdc(6'h0b, 8'h00);
    // upper port a pins driven, low pins still read the board
    wr(6'h01, 8'hf0);
    wr(6'h00, 8'h30);
    rdc(6'h00, 8'h3b);
    chk("a out", {24'h0, pa_out}, 32'h30);
    chk("a oe", {24'h0, pa_oe}, 32'hf0);
    chk("a pull en out", {24'h0, pa_pull_en}, 32'h0f);
    $display("t_irq done");
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    {ext_a, ext_b, ext_c} = {8'hff, 8'h3c, 8'h00};
    {n_mismatch, n_checks} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_portc;
    t_irq;
    conclude;
  end
  // about 220 cycles of work, cut off at 10000
  initial begin
    #1000000;
    n_mismatch++;
    conclude;
  end
endmodule
`default_nettype wire
